// ---- src/spcg_pkg.sv ----
// Purpose: constants, types and helpers for the sleep-mode clock gating bank
// Assumes: Avalon-MM byte addressing, 32-bit data, one word per register
// Notes: gate vectors are carried packed by peripheral index 0..11
package spcg_pkg;
  localparam logic [11:0] RUN_CLK_CFG_OFS = 12'h060;
  localparam logic [11:0] RUN_GATE1_OFS = 12'h104;
  localparam logic [11:0] SLEEP_GATE1_OFS = 12'h114;
  localparam logic [11:0] DEEP_GATE1_OFS = 12'h124;
  localparam logic [11:0] FAULT_STAT_OFS = 12'h1F0;
  localparam logic [31:0] GATE_RESET = 32'h0000_0000;
  localparam logic [31:0] GATE_RW_MASK = 32'h0307_5037;
  localparam logic [31:0] RUN_CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] RUN_CFG_RW_MASK = 32'h0800_0000;
  localparam int AUTO_SEL_POS = 27;
  localparam int COMPARATOR_B_POS = 25;
  localparam int COMPARATOR_A_POS = 24;
  localparam int GP_COUNTER_C_POS = 18;
  localparam int GP_COUNTER_B_POS = 17;
  localparam int GP_COUNTER_A_POS = 16;
  localparam int TWOWIRE_BUS_B_POS = 14;
  localparam int TWOWIRE_BUS_A_POS = 12;
  localparam int SYNC_SERIAL_B_POS = 5;
  localparam int SYNC_SERIAL_A_POS = 4;
  localparam int SERIAL_PORT_C_POS = 2;
  localparam int SERIAL_PORT_B_POS = 1;
  localparam int SERIAL_PORT_A_POS = 0;
  localparam int PERIPH_COUNT = 12;
  localparam logic [3:0] PERIPH_LAST_IDX = 4'hB;
  localparam int FAULT_FLAG_POS = 0;
  localparam int FAULT_IDX_LSB = 4;
  localparam int SRC_SEL_LSB = 8;
  localparam logic [1:0] SRC_RUN = 2'h0;
  localparam logic [1:0] SRC_SLEEP = 2'h1;
  localparam logic [1:0] SRC_DEEP = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_ACK = 2'h1
  } spcg_bus_state_t;

  // peripheral index to its bit in a gating word
  function automatic logic [4:0] gate_pos(input logic [3:0] idx);
    logic [4:0] pos;
    pos = 5'h00;
    case (idx)
      4'h0: pos = 5'(SERIAL_PORT_A_POS);
      4'h1: pos = 5'(SERIAL_PORT_B_POS);
      4'h2: pos = 5'(SERIAL_PORT_C_POS);
      4'h3: pos = 5'(SYNC_SERIAL_A_POS);
      4'h4: pos = 5'(SYNC_SERIAL_B_POS);
      4'h5: pos = 5'(TWOWIRE_BUS_A_POS);
      4'h6: pos = 5'(TWOWIRE_BUS_B_POS);
      4'h7: pos = 5'(GP_COUNTER_A_POS);
      4'h8: pos = 5'(GP_COUNTER_B_POS);
      4'h9: pos = 5'(GP_COUNTER_C_POS);
      4'hA: pos = 5'(COMPARATOR_A_POS);
      4'hB: pos = 5'(COMPARATOR_B_POS);
      default: pos = 5'h00;
    endcase
    return pos;
  endfunction

  // byte-enable merge limited to the writable bits
  function automatic logic [31:0] be_merge(
    input logic [31:0] old,
    input logic [31:0] wdata,
    input logic [3:0] be,
    input logic [31:0] mask
  );
    logic [31:0] laneMask;
    laneMask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & mask;
    return (old & ~laneMask) | (wdata & laneMask);
  endfunction
endpackage

// ---- src/spcg_fault_check.sv ----
// Purpose: answers each peripheral access with pass or bus fault
// Assumes: access strobe and index come from logic on mclk
// Notes: outputs are one-cycle pulses, one cycle after the strobe
`timescale 1ns/1ps
module spcg_fault_check (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic accValid,
  input wire logic [3:0] accIndex,
  input wire logic [11:0] gateVec,
  output logic accFault_ff,
  output logic accOk_ff
);
  wire idxKnown = (accIndex <= spcg_pkg::PERIPH_LAST_IDX);
  // unknown index has no clock at all, so it faults too
  wire gateOn = idxKnown & gateVec[accIndex];
  wire nxt_accFault = accValid & ~gateOn;
  wire nxt_accOk = accValid & gateOn;

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      accFault_ff <= 1'b0;
      accOk_ff <= 1'b0;
    end
    else if (clkEn)
    begin
      accFault_ff <= nxt_accFault;
      accOk_ff <= nxt_accOk;
    end
  end
endmodule

// ---- src/spcg_gating_bank.sv ----
// Purpose: run, sleep and deep-sleep peripheral clock gating bank
// Assumes: mode inputs and access strobes are synchronous to mclk
// Notes: the gate in force is registered, so a change shows one cycle late
// Function
// - sleep gating register sits at offset 0x114, 32 bits wide.
// - in sleep, a set bit clocks its peripheral, clear stops it.
// - access to a peripheral with its clock off returns a bus fault.
// - reset clears every gating bit; the register resets to zero.
// - run register in run, sleep register in sleep, deep register in deep; the code also needs auto gating select set for deep, else run.
// - sleep gating applies only with auto gating select set, else run.
// - bits 25 and 24 gate comparators b and a, read/write.
// - bits 18, 17, 16 gate counters c, b, a, read/write.
// - bits 14 and 12 gate two-wire buses b and a, read/write.
// - bits 5 and 4 gate synchronous serial b and a, read/write.
// - bits 2, 1, 0 gate serial ports c, b, a, read/write.
// - reserved bits are read-only and read as zero.
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
module spcg_gating_bank (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic [1:0] avs_response,
  output logic avs_waitrequest,
  input wire logic sleepMode,
  input wire logic deepSleepMode,
  input wire logic periphAccValid,
  input wire logic [3:0] periphAccIndex,
  output logic periphAccFault,
  output logic periphAccOk,
  output logic [11:0] periphClkEn,
  output logic [1:0] gateSource
);
  spcg_pkg::spcg_bus_state_t busState_ff;
  spcg_pkg::spcg_bus_state_t nxt_busState;
  logic waitReq_ff;
  logic [31:0] readData_ff;
  logic [1:0] response_ff;
  logic [31:0] runClkCfg_ff;
  logic [31:0] runGate_ff;
  logic [31:0] sleepGate_ff;
  logic [31:0] deepGate_ff;
  logic faultFlag_ff;
  logic [3:0] faultIdx_ff;
  logic [3:0] lastAccIdx_ff;
  logic [11:0] periphClkEn_ff;
  logic [1:0] gateSource_ff;
  logic [31:0] nxt_runClkCfg;
  logic [31:0] nxt_runGate;
  logic [31:0] nxt_sleepGate;
  logic [31:0] nxt_deepGate;
  logic nxt_faultFlag;
  logic [3:0] nxt_faultIdx;
  logic [31:0] effGate;
  logic [11:0] nxt_periphClkEn;
  logic [1:0] nxt_gateSource;
  logic faultPulse;
  logic okPulse;

  // address decode
  wire busReq = avs_read | avs_write;
  wire hitRunCfg = (avs_address == spcg_pkg::RUN_CLK_CFG_OFS);
  wire hitRunGate = (avs_address == spcg_pkg::RUN_GATE1_OFS);
  wire hitSleepGate = (avs_address == spcg_pkg::SLEEP_GATE1_OFS);
  wire hitDeepGate = (avs_address == spcg_pkg::DEEP_GATE1_OFS);
  wire hitFaultStat = (avs_address == spcg_pkg::FAULT_STAT_OFS);
  wire hitAny = hitRunCfg | hitRunGate | hitSleepGate | hitDeepGate | hitFaultStat;

  // a write lands only at the edge where the master sees waitrequest low
  wire wrCommit = (busState_ff == spcg_pkg::BUS_ACK) & avs_write & clkEn;
  wire wrRunCfg = wrCommit & hitRunCfg;
  wire wrRunGate = wrCommit & hitRunGate;
  wire wrSleepGate = wrCommit & hitSleepGate;
  wire wrDeepGate = wrCommit & hitDeepGate;
  wire wrFaultStat = wrCommit & hitFaultStat;
  wire faultClear = wrFaultStat & avs_writedata[spcg_pkg::FAULT_FLAG_POS]
    & avs_byteenable[0];

  wire [31:0] faultStatWord = {
    22'h00_0000,
    gateSource_ff,
    faultIdx_ff,
    3'h0,
    faultFlag_ff
  };

  // read mux; unmapped reads return zero
  wire [31:0] rdMux =
    hitRunCfg ? runClkCfg_ff :
    hitRunGate ? runGate_ff :
    hitSleepGate ? sleepGate_ff :
    hitDeepGate ? deepGate_ff :
    hitFaultStat ? faultStatWord :
    32'h0000_0000;
  wire [1:0] respSel = hitAny ? spcg_pkg::RESP_OKAY : spcg_pkg::RESP_DECERR;

  // next values; mask keeps reserved bits at zero
  assign nxt_runClkCfg = wrRunCfg ?
    spcg_pkg::be_merge(runClkCfg_ff, avs_writedata, avs_byteenable,
      spcg_pkg::RUN_CFG_RW_MASK) : runClkCfg_ff;
  assign nxt_runGate = wrRunGate ?
    spcg_pkg::be_merge(runGate_ff, avs_writedata, avs_byteenable,
      spcg_pkg::GATE_RW_MASK) : runGate_ff;
  assign nxt_sleepGate = wrSleepGate ?
    spcg_pkg::be_merge(sleepGate_ff, avs_writedata, avs_byteenable,
      spcg_pkg::GATE_RW_MASK) : sleepGate_ff;
  assign nxt_deepGate = wrDeepGate ?
    spcg_pkg::be_merge(deepGate_ff, avs_writedata, avs_byteenable,
      spcg_pkg::GATE_RW_MASK) : deepGate_ff;

  // source of the gate in force; deep-sleep wins if both modes assert
  wire autoSel = runClkCfg_ff[spcg_pkg::AUTO_SEL_POS];
  wire useDeep = autoSel & deepSleepMode;
  wire useSleep = autoSel & sleepMode & ~deepSleepMode;
  assign effGate = useDeep ? deepGate_ff : (useSleep ? sleepGate_ff : runGate_ff);
  assign nxt_gateSource = useDeep ? spcg_pkg::SRC_DEEP :
    (useSleep ? spcg_pkg::SRC_SLEEP : spcg_pkg::SRC_RUN);

  // pack the gating word into one enable per peripheral
  genvar g;
  generate
    for (g = 0; g < spcg_pkg::PERIPH_COUNT; g = g + 1)
    begin : gen_pack
      assign nxt_periphClkEn[g] = effGate[spcg_pkg::gate_pos(4'(g))];
    end
  endgenerate

  // fault flag is sticky; a new fault beats a clear in the same cycle
  assign nxt_faultFlag = faultPulse | (faultFlag_ff & ~faultClear);
  assign nxt_faultIdx = faultPulse ? lastAccIdx_ff : faultIdx_ff;

  // handshake: one wait cycle, then one cycle with waitrequest low
  always_comb
  begin
    case (busState_ff)
      spcg_pkg::BUS_IDLE: nxt_busState = busReq ? spcg_pkg::BUS_ACK : spcg_pkg::BUS_IDLE;
      spcg_pkg::BUS_ACK: nxt_busState = spcg_pkg::BUS_IDLE;
      default: nxt_busState = spcg_pkg::BUS_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      busState_ff <= spcg_pkg::BUS_IDLE;
      waitReq_ff <= 1'b1;
    end
    else if (clkEn)
    begin
      busState_ff <= nxt_busState;
      waitReq_ff <= (nxt_busState != spcg_pkg::BUS_ACK);
    end
  end

  // read data and response are loaded as waitrequest falls
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      readData_ff <= 32'h0000_0000;
      response_ff <= spcg_pkg::RESP_OKAY;
    end
    else if (clkEn && busState_ff == spcg_pkg::BUS_IDLE && busReq)
    begin
      readData_ff <= avs_read ? rdMux : 32'h0000_0000;
      response_ff <= respSel;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      runClkCfg_ff <= spcg_pkg::RUN_CFG_RESET;
      runGate_ff <= spcg_pkg::GATE_RESET;
      sleepGate_ff <= spcg_pkg::GATE_RESET;
      deepGate_ff <= spcg_pkg::GATE_RESET;
    end
    else if (clkEn)
    begin
      runClkCfg_ff <= nxt_runClkCfg;
      runGate_ff <= nxt_runGate;
      sleepGate_ff <= nxt_sleepGate;
      deepGate_ff <= nxt_deepGate;
    end
  end

  // enables start off, so nothing runs until software opens it
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      periphClkEn_ff <= 12'h000;
      gateSource_ff <= spcg_pkg::SRC_RUN;
    end
    else if (clkEn)
    begin
      periphClkEn_ff <= nxt_periphClkEn;
      gateSource_ff <= nxt_gateSource;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      faultFlag_ff <= 1'b0;
      faultIdx_ff <= 4'h0;
      lastAccIdx_ff <= 4'h0;
    end
    else if (clkEn)
    begin
      faultFlag_ff <= nxt_faultFlag;
      faultIdx_ff <= nxt_faultIdx;
      lastAccIdx_ff <= periphAccValid ? periphAccIndex : lastAccIdx_ff;
    end
  end

  // checks against the enables in force, not the raw register words
  spcg_fault_check u_fault_check (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .accValid(periphAccValid),
    .accIndex(periphAccIndex),
    .gateVec(periphClkEn_ff),
    .accFault_ff(faultPulse),
    .accOk_ff(okPulse)
  );

  assign avs_readdata = readData_ff;
  assign avs_response = response_ff;
  assign avs_waitrequest = waitReq_ff;
  assign periphAccFault = faultPulse;
  assign periphAccOk = okPulse;
  assign periphClkEn = periphClkEn_ff;
  assign gateSource = gateSource_ff;
endmodule

// ---- verification/spcg_gating_sva.sv ----
// Purpose: port-level checks of the gating bank handshake, gating and faults
// Assumes: one mclk domain; clkEn low freezes every output
// Notes: internal register state is not visible, so checks tie outputs to inputs
`timescale 1ns/1ps
module spcg_gating_sva (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [1:0] avs_response,
  input wire logic avs_waitrequest,
  input wire logic sleepMode,
  input wire logic deepSleepMode,
  input wire logic periphAccValid,
  input wire logic [3:0] periphAccIndex,
  input wire logic periphAccFault,
  input wire logic periphAccOk,
  input wire logic [11:0] periphClkEn,
  input wire logic [1:0] gateSource
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire logic mapped = avs_address inside {spcg_pkg::RUN_CLK_CFG_OFS, spcg_pkg::RUN_GATE1_OFS,
    spcg_pkg::SLEEP_GATE1_OFS, spcg_pkg::DEEP_GATE1_OFS, spcg_pkg::FAULT_STAT_OFS};
  property p_wait_one; !avs_waitrequest && clkEn |=> avs_waitrequest; endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
  property p_answer; (avs_read || avs_write) && avs_waitrequest && clkEn |=> !avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer after one cycle");
  property p_no_stray_ack; !avs_waitrequest && $past(clkEn) |-> $past(avs_read || avs_write);
  endproperty
  a_no_stray_ack: assert property (p_no_stray_ack) else $error("answer without request");
  property p_decode; !avs_waitrequest |-> ((avs_response == spcg_pkg::RESP_DECERR) != mapped);
  endproperty
  a_decode: assert property (p_decode) else $error("wrong response for address");
  property p_one_answer; periphAccValid && clkEn |=> periphAccFault != periphAccOk; endproperty
  a_one_answer: assert property (p_one_answer) else $error("access not answered once");
  property p_fault_val; periphAccValid && clkEn |=> periphAccFault ==
    ($past(periphAccIndex) > 4'hB || $past(periphClkEn[periphAccIndex]) == 1'b0); endproperty
  a_fault_val: assert property (p_fault_val) else $error("fault disagrees with gate");
  property p_no_stray_acc; (periphAccFault || periphAccOk) && $past(clkEn) |->
    $past(periphAccValid); endproperty
  a_no_stray_acc: assert property (p_no_stray_acc) else $error("answer without access");
  property p_src_deep; gateSource == spcg_pkg::SRC_DEEP && $past(clkEn) |->
    $past(deepSleepMode); endproperty
  a_src_deep: assert property (p_src_deep) else $error("deep word outside deep sleep");
  property p_src_sleep; gateSource == spcg_pkg::SRC_SLEEP && $past(clkEn) |->
    $past(sleepMode && !deepSleepMode); endproperty
  a_src_sleep: assert property (p_src_sleep) else $error("sleep word outside sleep");
endmodule
bind spcg_gating_bank spcg_gating_sva u_sva (.mclk(mclk), .sys_rst(sys_rst), .clkEn(clkEn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_response(avs_response), .avs_waitrequest(avs_waitrequest), .sleepMode(sleepMode),
  .deepSleepMode(deepSleepMode), .periphAccValid(periphAccValid),
  .periphAccIndex(periphAccIndex), .periphAccFault(periphAccFault), .periphAccOk(periphAccOk),
  .periphClkEn(periphClkEn), .gateSource(gateSource));

// ---- verification/tb_top.sv ----
// Purpose: self-checking bench for the sleep-mode clock gating bank
// Assumes: Avalon-MM master in this bench, clkEn dropped only while the bus is idle
// Notes: one idle cycle between bus transfers keeps each signal single-driven per step
`timescale 1ns/1ps
module tb_top;
  logic mclk, sys_rst, clkEn, avs_read, avs_write, sleepMode, deepSleepMode, periphAccValid;
  logic avs_waitrequest, periphAccFault, periphAccOk, fe;
  logic [11:0] avs_address, periphClkEn;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable, periphAccIndex;
  logic [1:0] avs_response, gateSource;
  int bad_count, checks_done, seed;
  logic [33:0] busQ[$];
  logic fltQ[$];
  localparam int POS [12] = '{0, 1, 2, 4, 5, 12, 14, 16, 17, 18, 24, 25};
  spcg_gating_bank uut (.mclk(mclk), .sys_rst(sys_rst), .clkEn(clkEn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_response(avs_response),
    .avs_waitrequest(avs_waitrequest), .sleepMode(sleepMode), .deepSleepMode(deepSleepMode),
    .periphAccValid(periphAccValid), .periphAccIndex(periphAccIndex),
    .periphAccFault(periphAccFault), .periphAccOk(periphAccOk), .periphClkEn(periphClkEn),
    .gateSource(gateSource));
  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("counts: %0d checks, %0d mismatches", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] be, input logic [33:0] exp);
    int n;
    @(posedge mclk);
    busQ.push_back(exp);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 20)
    begin
      bad_count++;
      close_out();
    end
  endtask
  task automatic acc(input logic [3:0] i, input logic f);
    @(posedge mclk);
    fltQ.push_back(f);
    periphAccValid <= 1'b1;
    periphAccIndex <= i;
    @(posedge mclk);
    periphAccValid <= 1'b0;
  endtask
  function automatic logic [11:0] pack(input logic [31:0] w);
    for (int i = 0; i < 12; i++)
      pack[i] = w[POS[i]];
  endfunction
  // monitor: oldest note is matched against each answer as it appears
  always @(posedge mclk)
  begin
    if (!sys_rst && avs_waitrequest === 1'b0)
      check("bus", {avs_response, avs_readdata}, busQ.pop_front());
    if (periphAccFault === 1'b1 || periphAccOk === 1'b1)
    begin
      fe = fltQ.pop_front();
      check("access", {periphAccFault, periphAccOk}, {fe, !fe});
    end
  end
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial
  begin
    logic [31:0] w [3];
    logic [11:0] ofs [3];
    logic [31:0] r, lm;
    logic [3:0] be;
    logic [1:0] src;
    logic [11:0] gv;
    ofs = '{spcg_pkg::RUN_GATE1_OFS, spcg_pkg::SLEEP_GATE1_OFS, spcg_pkg::DEEP_GATE1_OFS};
    w = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
    seed = 37099;
    {sys_rst, clkEn} = 2'h3;
    {avs_read, avs_write, sleepMode, deepSleepMode, periphAccValid} = 5'h00;
    {avs_address, avs_writedata, avs_byteenable, periphAccIndex} = 52'h0;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int k = 0; k < 3; k++)
      bus(1'b0, ofs[k], 32'h0, 4'hF, {spcg_pkg::RESP_OKAY, spcg_pkg::GATE_RESET});
    $display("test reset values done");
    bus(1'b1, ofs[1], 32'hFFFF_FFFF, 4'hF, 34'h0);
    w[1] = spcg_pkg::GATE_RW_MASK;
    bus(1'b0, ofs[1], 32'h0, 4'hF, {spcg_pkg::RESP_OKAY, w[1]});
    for (int n = 0; n < 18; n++)
    begin
      r = $random(seed);
      be = 4'($random(seed));
      lm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & spcg_pkg::GATE_RW_MASK;
      w[n % 3] = (w[n % 3] & ~lm) | (r & lm);
      bus(1'b1, ofs[n % 3], r, be, 34'h0);
      bus(1'b0, ofs[n % 3], 32'h0, 4'hF, {spcg_pkg::RESP_OKAY, w[n % 3]});
    end
    $display("test register access done");
    for (int j = 0; j < 8; j++)
    begin
      sleepMode <= j[1];
      deepSleepMode <= j[0];
      bus(1'b1, spcg_pkg::RUN_CLK_CFG_OFS, {4'h0, j[2], 27'h0}, 4'hF, 34'h0);
      repeat (3) @(posedge mclk);
      src = !j[2] ? spcg_pkg::SRC_RUN : j[0] ? spcg_pkg::SRC_DEEP : j[1] ? spcg_pkg::SRC_SLEEP :
        spcg_pkg::SRC_RUN;
      check("source", gateSource, src);
      gv = pack(w[src]);
      check("gate", periphClkEn, gv);
      for (int i = 0; i < 16; i++)
        acc(4'(i), i > 11 || !gv[i]);
    end
    $display("test gate selection done");
    // let the last answer clear before the freeze, or its pulse would stand
    @(posedge mclk);
    clkEn <= 1'b0;
    deepSleepMode <= 1'b0;
    repeat (3) @(posedge mclk);
    check("frozen source", gateSource, spcg_pkg::SRC_DEEP);
    clkEn <= 1'b1;
    repeat (2) @(posedge mclk);
    check("thawed source", gateSource, spcg_pkg::SRC_SLEEP);
    check("thawed gate", periphClkEn, pack(w[spcg_pkg::SRC_SLEEP]));
    $display("test clock enable done");
    bus(1'b0, 12'h200, 32'h0, 4'hF, {spcg_pkg::RESP_DECERR, 32'h0});
    bus(1'b1, 12'h118, 32'hFFFF_FFFF, 4'hF, {spcg_pkg::RESP_DECERR, 32'h0});
    bus(1'b0, ofs[1], 32'h0, 4'hF, {spcg_pkg::RESP_OKAY, w[1]});
    $display("test unmapped done");
    bus(1'b0, spcg_pkg::FAULT_STAT_OFS, 32'h0, 4'hF,
      {spcg_pkg::RESP_OKAY, 22'h0, spcg_pkg::SRC_SLEEP, 4'hF, 4'h1});
    bus(1'b1, spcg_pkg::FAULT_STAT_OFS, 32'h1, 4'h1, 34'h0);
    bus(1'b0, spcg_pkg::FAULT_STAT_OFS, 32'h0, 4'hF,
      {spcg_pkg::RESP_OKAY, 22'h0, spcg_pkg::SRC_SLEEP, 4'hF, 4'h0});
    $display("test fault status done");
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    bus(1'b0, ofs[1], 32'h0, 4'hF, {spcg_pkg::RESP_OKAY, spcg_pkg::GATE_RESET});
    check("gate", periphClkEn, 12'h000);
    repeat (3) @(posedge mclk);
    check("pending", 34'(busQ.size() + fltQ.size()), 34'h0);
    $display("test second reset done");
    close_out();
  end
endmodule
